// >>> verification/gmo_mem_ctrl_model.sv
`timescale 1ns/1ns
module gmo_mem_ctrl_model (
  // Clock
  input wire logic mclk,
  // Address bus towards the aperture decoder
  output logic sysValid,
  output logic [31:0] sysAddr,
  // Decode result
  input wire logic apertureHit,
  input wire logic [21:0] apertureOffset
);
  // Bus idle at start
  initial begin
    sysValid = 1'b0;
    sysAddr = 32'h0000_0000;
  end
  // One address cycle; idle bus shows inverted address, not a stale copy
  task automatic access(input logic [31:0] a, output logic hit,
                        output logic [21:0] ofs);
    @(negedge mclk);
    sysValid = 1'b1;
    sysAddr = a;
    @(negedge mclk);
    sysValid = 1'b0;
    sysAddr = ~a;
    hit = apertureHit;
    ofs = apertureOffset;
  endtask : access
endmodule : gmo_mem_ctrl_model

// >>> verification/tb.sv
`timescale 1ns/1ns
module tb;
  import gmo_pkg::*;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  gmo_reg_req_type regReq = '0;
  logic [31:0] regRdData;
  logic regRdValid;
  logic sysValid;
  logic [31:0] sysAddr;
  logic apertureHit;
  logic [21:0] apertureOffset;
  gmo_pix_req_type pixReq = '0;
  gmo_mem_acc_type memAcc;
  logic unlocked;
  logic modeInvalid;
  int failures = 0;
  int tests_run = 0;
  int fb, cb, cur, pitch;
  int wTab[4] = '{640, 800, 1024, 1280};
  int hTab[4] = '{480, 600, 768, 1024};
  int szTab[4] = '{0, 3, 8, 9};
  logic [3:0] apSize;
  logic [3:0] vgaBase = 4'h5;
  logic [12:0] apStart = 13'h0010;
  logic [31:0] rd, a;
  logic v, hit;
  logic [21:0] ofs;

  // Clock
  always #2 mclk = ~mclk;

  gmo_memory_org i_dut (.mclk(mclk), .resetn(resetn), .regReq(regReq),
    .regRdData(regRdData), .regRdValid(regRdValid), .sysValid(sysValid),
    .sysAddr(sysAddr), .apertureHit(apertureHit),
    .apertureOffset(apertureOffset), .pixReq(pixReq), .memAcc(memAcc),
    .unlocked(unlocked), .modeInvalid(modeInvalid));

  gmo_mem_ctrl_model i_mem (.mclk(mclk), .sysValid(sysValid),
    .sysAddr(sysAddr), .apertureHit(apertureHit),
    .apertureOffset(apertureOffset));

  // Compare and count
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Register cycles, request held for exactly one edge
  task automatic regWrite(input logic [15:0] ad, input logic [31:0] d);
    @(negedge mclk);
    regReq = '{1'b1, 1'b0, ad, 4'hF, d};
    @(negedge mclk);
    regReq = '0;
  endtask : regWrite

  task automatic regRead(input logic [15:0] ad, output logic [31:0] d,
                         output logic vv);
    @(negedge mclk);
    regReq = '{1'b0, 1'b1, ad, 4'h0, 32'h0000_0000};
    @(negedge mclk);
    regReq = '0;
    vv = regRdValid;
    d = regRdData;
  endtask : regRead

  task automatic readCheck(input logic [15:0] ad, input logic [31:0] exp);
    logic [31:0] d;
    logic vv;
    regRead(ad, d, vv);
    check({vv, d}, {1'b1, exp});
  endtask : readCheck

  // Expected buffer access for a mode m = {res, bpp16}
  function automatic logic [25:0] expAcc(input int sel, input int x,
                                         input int y, input int m);
    int o, bpb, sh;
    logic [21:0] off;
    logic [3:0] be;
    logic inAp;
    bpb = m[0] ? 2 : 1;
    sh = (m[0] || m[2:1] == 2'd3) ? 11 : 10;
    case (sel)
      0: o = fb + ((y << sh) | (x * bpb));
      1: o = (m[2:1] == 2'd2) ? cb + y * pitch + x :
             fb + ((y << sh) | (wTab[m[2:1]] * bpb)) + x;
      2: o = (vgaBase << 18) + ((y * 320 + x) % 262144);
      3: o = (vgaBase << 18) + (((y * 80 + (x >> 3)) << 2) % 262144);
      default: o = cur + (y << 3) + x;
    endcase
    off = o[21:0];
    if (sel == 3) be = 4'hF;
    else if (sel == 0 && m[0]) be = off[1] ? 4'hC : 4'h3;
    else be = 4'h1 << off[1:0];
    inAp = (apSize >= 4'h8) || (off < (22'(apSize) << 19));
    return {1'b1, inAp, off[21:2], be};
  endfunction : expAcc

  // One pixel request, result one cycle later
  task automatic pixel(input int sel, input int x, input int y, input int m);
    @(negedge mclk);
    pixReq = '{1'b1, gmo_buf_type'(sel), 11'(x), 11'(y)};
    @(negedge mclk);
    pixReq = '0;
    check(memAcc, expAcc(sel, x, y, m));
  endtask : pixel

  // Closing verdict
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop

  // Watchdog
  initial begin
    #40000;
    failures++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    rd = $urandom(78828);
    repeat (12) @(negedge mclk);
    resetn = 1'b1;
    check({memAcc, apertureHit, modeInvalid, unlocked}, 64'h0);
    readCheck(OFS_WRITE_LOCK_KEY, 32'h0000_0000);
    // Locked write is dropped
    regWrite(OFS_GENERAL_CONFIG, 32'h0000_0003);
    readCheck(OFS_GENERAL_CONFIG, 32'h0000_0000);
    regWrite(OFS_WRITE_LOCK_KEY, UNLOCK_KEY);
    check(unlocked, 1'b1);
    // Buffer starts inside 4 MB
    fb = $urandom & 32'h003F_F800;
    cb = $urandom & 32'h003F_FFFC;
    cur = $urandom & 32'h003F_FFF0;
    pitch = $urandom & 32'h0000_03FF;
    regWrite(OFS_FRAME_BUFFER_START, fb);
    regWrite(OFS_COMPRESSED_BUFFER_START, cb);
    regWrite(OFS_POINTER_PATTERN_START, cur);
    regWrite(OFS_LINE_SPACING, {10'h0, pitch[9:0], 12'hFFF});
    readCheck(OFS_FRAME_BUFFER_START, fb);
    readCheck(OFS_POINTER_PATTERN_START, cur);
    regWrite(OFS_RESERVED_GAP, $urandom);
    readCheck(OFS_RESERVED_GAP, 32'h0000_0000);
    regRead(16'h8400, rd, v);
    check(v, 1'b0);
    regRead(16'h82FC, rd, v);
    check(v, 1'b0);
    // Aperture set up before any fetch
    for (int i = 0; i < 4; i++) begin
      regWrite(OFS_APERTURE_CONFIG, {11'h0, vgaBase, 4'(szTab[i]), apStart});
      for (int k = 0; k < 6; k++) begin
        case (k)
          0: a = (32'(apStart) << 19) - 1;
          1: a = 32'(apStart) << 19;
          2: a = (32'(apStart) << 19) + ((szTab[i] > 8 ? 8 : szTab[i]) << 19) - 1;
          3: a = (32'(apStart) << 19) + ((szTab[i] > 8 ? 8 : szTab[i]) << 19);
          default: a = (32'(apStart) << 19) + ($urandom & 32'h003F_FFFF);
        endcase
        i_mem.access(a, hit, ofs);
        v = (a >= (32'(apStart) << 19)) && (a < (32'(apStart) << 19) +
            ((szTab[i] > 8 ? 8 : szTab[i]) << 19));
        check(hit, v);
        if (v) check(ofs, a[21:0] - {apStart[2:0], 19'h0});
      end
    end
    // Every mode, every buffer kind
    for (int m = 0; m < 8; m++) begin
      apSize = m[0] ? 4'h8 : 4'h4;
      regWrite(OFS_APERTURE_CONFIG, {11'h0, vgaBase, apSize, apStart});
      regWrite(OFS_GENERAL_CONFIG, 32'(m));
      @(negedge mclk);
      check(modeInvalid, m == 7);
      readCheck(OFS_LINE_SPACING, {10'h0, pitch[9:0],
        (m[0] || m[2:1] == 2'd3) ? 12'h800 : 12'h400});
      // All five buffer kinds: last pixel, start of row 1, four random pixels
      for (int s = 0; s < 5; s++) begin
        pixel(s, wTab[m[2:1]] - 1, hTab[m[2:1]] - 1, m);
        pixel(s, 0, 1, m);
        repeat (4) pixel(s, $urandom % wTab[m[2:1]], $urandom % hTab[m[2:1]], m);
      end
    end
    // Relock, then a protected write is ignored
    regWrite(OFS_WRITE_LOCK_KEY, 32'h0000_0000);
    check(unlocked, 1'b0);
    regWrite(OFS_FRAME_BUFFER_START, ~fb);
    readCheck(OFS_FRAME_BUFFER_START, fb);
    report_and_stop();
  end
endmodule : tb

// >>> verilog/gmo_memory_org.sv
`timescale 1ns/1ns
// Function
// - Graphics memory up to 4 MB above RAM
// - Aperture sits at top of installed RAM
// - Aperture start and size in 512 KB steps
// - Accesses use 20-bit dword offset, byte enables
// - Frame offset concatenates row above column
// - 8-bpp modes except 1280 use 1024-byte delta
// - 16-bpp and 1280x8 use 2048-byte delta
// - Compressed line stored in gap after line
// - 1024x768 compressed buffer linear after frame
// - Leftmost pixel in lowest byte of dword
// - Supported resolutions and depths per mode
// - VGA data in 256 KB aperture region
// - Direct refresh of mode 13h and planar modes
// - Register bank is 100h bytes at 8300h
// - Programmable starts, line spacing, buffer size
// - Lock blocks critical writes, reads always allowed
module gmo_memory_org
  import gmo_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Memory-mapped register port
  input wire gmo_reg_req_type regReq,
  output logic [31:0] regRdData,
  output logic regRdValid,
  // System address decode
  input wire logic sysValid,
  input wire logic [31:0] sysAddr,
  output logic apertureHit,
  output logic [21:0] apertureOffset,
  // Pixel and buffer access
  input wire gmo_pix_req_type pixReq,
  output gmo_mem_acc_type memAcc,
  // Status
  output logic unlocked,
  output logic modeInvalid
);

  // Line delta shift for a display mode
  function automatic int unsigned lineShift(input logic bpp16,
                                            input gmo_res_type res);
    if (bpp16 || res == RES_1280) begin
      return SHIFT_DELTA_2K;
    end
    return SHIFT_DELTA_1K;
  endfunction : lineShift

  // Active width in pixels
  function automatic logic [10:0] resWidth(input gmo_res_type res);
    case (res)
      RES_640: resWidth = WIDTH_640;
      RES_800: resWidth = WIDTH_800;
      RES_1024: resWidth = WIDTH_1024;
      default: resWidth = WIDTH_1280;
    endcase
  endfunction : resWidth

  // Byte-lane merge of a register write
  function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                             input logic [31:0] wr,
                                             input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wr[8*i +: 8];
      end
    end
    return r;
  endfunction : mergeBytes

  // Register bank state
  logic [31:0] lockKey_ff, nxt_lockKey;
  logic [31:0] genCfg_ff, nxt_genCfg;
  logic [31:0] timCfg_ff, nxt_timCfg;
  logic [31:0] outCfg_ff, nxt_outCfg;
  logic [31:0] fbStart_ff, nxt_fbStart;
  logic [31:0] cbStart_ff, nxt_cbStart;
  logic [31:0] curStart_ff, nxt_curStart;
  logic [31:0] vidStart_ff, nxt_vidStart;
  logic [31:0] lineSp_ff, nxt_lineSp;
  logic [31:0] bufSize_ff, nxt_bufSize;
  logic [31:0] apCfg_ff, nxt_apCfg;
  logic [31:0] rdData_ff, nxt_rdData;
  logic rdValid_ff, nxt_rdValid;

  // Decoded configuration
  logic bpp16;
  gmo_res_type res;
  logic [12:0] apStart;
  logic [3:0] apSize;
  logic [3:0] vgaBase;
  logic [11:0] frameDelta;
  logic inWindow;

  assign bpp16 = genCfg_ff[GC_BPP16_BIT];
  assign res = gmo_res_type'(genCfg_ff[GC_RES_LSB +: 2]);
  assign apStart = apCfg_ff[AP_START_LSB +: 13];
  assign apSize = apCfg_ff[AP_SIZE_LSB +: 4];
  assign vgaBase = apCfg_ff[AP_VGA_LSB +: 4];
  assign frameDelta = (lineShift(bpp16, res) == SHIFT_DELTA_2K) ?
                      DELTA_2K : DELTA_1K;
  assign unlocked = (lockKey_ff == UNLOCK_KEY);
  assign inWindow = (regReq.addr >= OFS_WINDOW_BASE) &&
                    (regReq.addr <= OFS_WINDOW_LAST);

  // Register writes, gated by the lock except the lock key itself
  always_comb begin
    logic wrOk;
    wrOk = regReq.write && unlocked;
    nxt_lockKey = lockKey_ff;
    nxt_genCfg = genCfg_ff;
    nxt_timCfg = timCfg_ff;
    nxt_outCfg = outCfg_ff;
    nxt_fbStart = fbStart_ff;
    nxt_cbStart = cbStart_ff;
    nxt_curStart = curStart_ff;
    nxt_vidStart = vidStart_ff;
    nxt_lineSp = lineSp_ff;
    nxt_bufSize = bufSize_ff;
    nxt_apCfg = apCfg_ff;
    if (regReq.write && regReq.addr == OFS_WRITE_LOCK_KEY) begin
      nxt_lockKey = mergeBytes(lockKey_ff, regReq.data, regReq.byteEn);
    end
    if (wrOk) begin
      case (regReq.addr)
        OFS_GENERAL_CONFIG: begin
          nxt_genCfg = mergeBytes(genCfg_ff, regReq.data, regReq.byteEn);
        end
        OFS_TIMING_CONFIG: begin
          nxt_timCfg = mergeBytes(timCfg_ff, regReq.data, regReq.byteEn);
        end
        OFS_OUTPUT_CONFIG: begin
          nxt_outCfg = mergeBytes(outCfg_ff, regReq.data, regReq.byteEn);
        end
        OFS_FRAME_BUFFER_START: begin
          nxt_fbStart = mergeBytes(fbStart_ff, regReq.data, regReq.byteEn);
        end
        OFS_COMPRESSED_BUFFER_START: begin
          nxt_cbStart = mergeBytes(cbStart_ff, regReq.data, regReq.byteEn);
        end
        OFS_POINTER_PATTERN_START: begin
          nxt_curStart = mergeBytes(curStart_ff, regReq.data,
                                    regReq.byteEn);
        end
        OFS_VIDEO_BUFFER_START: begin
          nxt_vidStart = mergeBytes(vidStart_ff, regReq.data,
                                    regReq.byteEn);
        end
        OFS_LINE_SPACING: begin
          nxt_lineSp = mergeBytes(lineSp_ff, regReq.data, regReq.byteEn);
        end
        OFS_LINE_BUFFER_SIZE: begin
          nxt_bufSize = mergeBytes(bufSize_ff, regReq.data, regReq.byteEn);
        end
        OFS_APERTURE_CONFIG: begin
          nxt_apCfg = mergeBytes(apCfg_ff, regReq.data, regReq.byteEn);
        end
        default: ;
      endcase
    end
  end

  // Register reads, never blocked by the lock
  always_comb begin
    nxt_rdValid = regReq.read && inWindow;
    nxt_rdData = RST_REG;
    if (regReq.read) begin
      case (regReq.addr)
        OFS_WRITE_LOCK_KEY: nxt_rdData = lockKey_ff;
        OFS_GENERAL_CONFIG: nxt_rdData = genCfg_ff;
        OFS_TIMING_CONFIG: nxt_rdData = timCfg_ff;
        OFS_OUTPUT_CONFIG: nxt_rdData = outCfg_ff;
        OFS_FRAME_BUFFER_START: nxt_rdData = fbStart_ff;
        OFS_COMPRESSED_BUFFER_START: nxt_rdData = cbStart_ff;
        OFS_POINTER_PATTERN_START: nxt_rdData = curStart_ff;
        OFS_VIDEO_BUFFER_START: nxt_rdData = vidStart_ff;
        OFS_LINE_SPACING: begin
          nxt_rdData = {lineSp_ff[31:LS_FRAME_MSB+1], frameDelta};
        end
        OFS_LINE_BUFFER_SIZE: nxt_rdData = bufSize_ff;
        OFS_APERTURE_CONFIG: nxt_rdData = apCfg_ff;
        default: nxt_rdData = RST_REG;
      endcase
    end
  end

  // Register bank flops
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      lockKey_ff <= RST_REG;
      genCfg_ff <= RST_REG;
      timCfg_ff <= RST_REG;
      outCfg_ff <= RST_REG;
      fbStart_ff <= RST_REG;
      cbStart_ff <= RST_REG;
      curStart_ff <= RST_REG;
      vidStart_ff <= RST_REG;
      lineSp_ff <= RST_REG;
      bufSize_ff <= RST_REG;
      apCfg_ff <= RST_REG;
      rdData_ff <= RST_REG;
      rdValid_ff <= 1'b0;
    end else begin
      lockKey_ff <= nxt_lockKey;
      genCfg_ff <= nxt_genCfg;
      timCfg_ff <= nxt_timCfg;
      outCfg_ff <= nxt_outCfg;
      fbStart_ff <= nxt_fbStart;
      cbStart_ff <= nxt_cbStart;
      curStart_ff <= nxt_curStart;
      vidStart_ff <= nxt_vidStart;
      lineSp_ff <= nxt_lineSp;
      bufSize_ff <= nxt_bufSize;
      apCfg_ff <= nxt_apCfg;
      rdData_ff <= nxt_rdData;
      rdValid_ff <= nxt_rdValid;
    end
  end

  assign regRdData = rdData_ff;
  assign regRdValid = rdValid_ff;

  // Aperture decode and offset state
  logic apHit_ff, nxt_apHit;
  logic [21:0] apOfs_ff, nxt_apOfs;
  logic modeBad_ff, nxt_modeBad;
  logic [3:0] apUnits;

  // Aperture size clamped at 4 MB
  assign apUnits = (apSize > MAX_APERTURE_UNITS) ?
                   MAX_APERTURE_UNITS : apSize;

  // Hit test against the programmed aperture window
  always_comb begin
    logic [13:0] apEnd;
    apEnd = {1'b0, apStart} + {10'h000, apUnits};
    nxt_apHit = sysValid && (apUnits != 4'h0) &&
                ({1'b0, sysAddr[31:APERTURE_UNIT_SHIFT]} >=
                 {1'b0, apStart}) &&
                ({1'b0, sysAddr[31:APERTURE_UNIT_SHIFT]} < apEnd);
    nxt_apOfs = sysAddr[21:0] - {apStart[2:0], 19'h0_0000};
    nxt_modeBad = bpp16 && (res == RES_1280);
  end

  // Address generation next state
  gmo_mem_acc_type acc_ff, nxt_acc;

  always_comb begin
    logic [21:0] rowBase;
    logic [21:0] xBytes;
    logic [21:0] lineBytes;
    logic [21:0] ofs;
    logic [21:0] apBytes;
    logic [9:0] cbPitch;
    rowBase = 22'(pixReq.y) << lineShift(bpp16, res);
    xBytes = bpp16 ? {10'h000, pixReq.x, 1'b0} : {11'h000, pixReq.x};
    lineBytes = bpp16 ? {10'h000, resWidth(res), 1'b0} :
                        {11'h000, resWidth(res)};
    cbPitch = lineSp_ff[LS_CB_LSB +: 10];
    apBytes = 22'(apUnits) << APERTURE_UNIT_SHIFT;
    ofs = 22'h00_0000;
    nxt_acc.byteEn = 4'h1 << pixReq.x[1:0];
    case (pixReq.sel)
      BUF_FRAME: begin
        ofs = fbStart_ff[21:0] + (rowBase | xBytes);
        if (bpp16) begin
          nxt_acc.byteEn = ofs[1] ? 4'hC : 4'h3;
        end else begin
          nxt_acc.byteEn = 4'h1 << ofs[1:0];
        end
      end
      BUF_COMP: begin
        if (res == RES_1024) begin
          ofs = cbStart_ff[21:0] + 22'(pixReq.y) * 22'(cbPitch) +
                {11'h000, pixReq.x};
        end else begin
          ofs = fbStart_ff[21:0] + (rowBase | lineBytes) +
                {11'h000, pixReq.x};
        end
        nxt_acc.byteEn = 4'h1 << ofs[1:0];
      end
      BUF_VGA13: begin
        ofs = (22'(vgaBase) << VGA_UNIT_SHIFT) +
              {4'h0, 18'(18'(pixReq.y) * 18'(VGA13_PITCH) +
                         18'(pixReq.x))};
        nxt_acc.byteEn = 4'h1 << ofs[1:0];
      end
      BUF_VGAPLANAR: begin
        ofs = (22'(vgaBase) << VGA_UNIT_SHIFT) +
              {4'h0, 18'((18'(pixReq.y) * 18'(VGA_PLANAR_PITCH) +
                          18'(pixReq.x[10:3])) << 2)};
        nxt_acc.byteEn = 4'hF;
      end
      BUF_CURSOR: begin
        ofs = curStart_ff[21:0] + (22'(pixReq.y) << CURSOR_LINE_SHIFT) +
              {11'h000, pixReq.x};
        nxt_acc.byteEn = 4'h1 << ofs[1:0];
      end
      default: begin
        ofs = 22'h00_0000;
      end
    endcase
    nxt_acc.valid = pixReq.valid;
    nxt_acc.wordOffset = ofs[21:2];
    nxt_acc.inAperture = (ofs < apBytes) || (apUnits == MAX_APERTURE_UNITS);
    if (!pixReq.valid) begin
      nxt_acc.byteEn = 4'h0;
    end
  end

  // Decode and address flops
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      apHit_ff <= 1'b0;
      apOfs_ff <= 22'h00_0000;
      modeBad_ff <= 1'b0;
      acc_ff <= '0;
    end else begin
      apHit_ff <= nxt_apHit;
      apOfs_ff <= nxt_apOfs;
      modeBad_ff <= nxt_modeBad;
      acc_ff <= nxt_acc;
    end
  end

  assign apertureHit = apHit_ff;
  assign apertureOffset = apOfs_ff;
  assign modeInvalid = modeBad_ff;
  assign memAcc = acc_ff;

  // Checks, all on the system clock
  default clocking chkClock @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  chk_lock_blocks_write: assert property (
    regReq.write && !unlocked && regReq.addr == OFS_GENERAL_CONFIG
    |=> $stable(genCfg_ff)) else $error("locked write changed config");
  chk_unlock_allows_write: assert property (
    regReq.write && unlocked && regReq.addr == OFS_FRAME_BUFFER_START &&
    regReq.byteEn == 4'hF |=> fbStart_ff == $past(regReq.data))
    else $error("unlocked write lost");
  chk_read_always_answers: assert property (
    regReq.read && regReq.addr == OFS_FRAME_BUFFER_START
    |=> regRdValid && regRdData == $past(fbStart_ff))
    else $error("read not answered");
  chk_window_bounds: assert property (
    regReq.read && (regReq.addr < OFS_WINDOW_BASE) |=> !regRdValid)
    else $error("read outside window answered");
  chk_delta_by_mode: assert property (
    regReq.read && regReq.addr == OFS_LINE_SPACING |=>
    regRdData[LS_FRAME_MSB:0] ==
    ($past(bpp16 || res == RES_1280) ? DELTA_2K : DELTA_1K))
    else $error("line delta wrong for mode");
  chk_aperture_max: assert property (
    apertureHit |-> $past(sysAddr[31:APERTURE_UNIT_SHIFT]) -
    $past(apStart) < 13'(MAX_APERTURE_UNITS))
    else $error("hit beyond 4 MB");
  chk_pixel_lane16: assert property (
    pixReq.valid && pixReq.sel == BUF_FRAME && bpp16
    |=> memAcc.byteEn == 4'h3 || memAcc.byteEn == 4'hC)
    else $error("16-bpp lanes wrong");
  chk_pixel_row_step: assert property (
    pixReq.valid && pixReq.sel == BUF_FRAME && pixReq.x == 11'h000 &&
    pixReq.y == 11'h001 && !bpp16 && res == RES_640
    |=> memAcc.wordOffset == $past(fbStart_ff[21:2]) + 20'h0_0100)
    else $error("row offset wrong");
  chk_mode_invalid: assert property (
    ##1 modeInvalid == $past(bpp16 && res == RES_1280))
    else $error("mode flag wrong");

endmodule : gmo_memory_org

// >>> verilog/gmo_pkg.sv
package gmo_pkg;

  // Register window relative to the control register base
  localparam logic [15:0] OFS_WINDOW_BASE = 16'h8300;
  localparam logic [15:0] OFS_WINDOW_LAST = 16'h83FF;
  localparam logic [15:0] OFS_WRITE_LOCK_KEY = 16'h8300;
  localparam logic [15:0] OFS_GENERAL_CONFIG = 16'h8304;
  localparam logic [15:0] OFS_TIMING_CONFIG = 16'h8308;
  localparam logic [15:0] OFS_OUTPUT_CONFIG = 16'h830C;
  localparam logic [15:0] OFS_FRAME_BUFFER_START = 16'h8310;
  localparam logic [15:0] OFS_COMPRESSED_BUFFER_START = 16'h8314;
  localparam logic [15:0] OFS_POINTER_PATTERN_START = 16'h8318;
  localparam logic [15:0] OFS_RESERVED_GAP = 16'h831C;
  localparam logic [15:0] OFS_VIDEO_BUFFER_START = 16'h8320;
  localparam logic [15:0] OFS_LINE_SPACING = 16'h8324;
  localparam logic [15:0] OFS_LINE_BUFFER_SIZE = 16'h8328;
  localparam logic [15:0] OFS_APERTURE_CONFIG = 16'h83F0;

  // Reset value shared by every register of the bank
  localparam logic [31:0] RST_REG = 32'h0000_0000;
  // Key that opens the protected registers (arbitrary value)
  localparam logic [31:0] UNLOCK_KEY = 32'h0000_A5C3;

  // General configuration fields
  localparam int GC_BPP16_BIT = 0;
  localparam int GC_RES_LSB = 1;
  // Aperture configuration fields
  localparam int AP_START_LSB = 0;
  localparam int AP_SIZE_LSB = 13;
  localparam int AP_VGA_LSB = 17;
  // Line spacing fields
  localparam int LS_FRAME_MSB = 11;
  localparam int LS_CB_LSB = 12;

  // Aperture granules and limits
  localparam int APERTURE_UNIT_SHIFT = 19;
  localparam logic [3:0] MAX_APERTURE_UNITS = 4'h8;
  localparam int VGA_UNIT_SHIFT = 18;
  localparam int VGA_SPAN_BITS = 18;
  localparam int SHIFT_DELTA_1K = 10;
  localparam int SHIFT_DELTA_2K = 11;
  localparam logic [11:0] DELTA_1K = 12'h400;
  localparam logic [11:0] DELTA_2K = 12'h800;
  localparam logic [8:0] VGA13_PITCH = 9'h140;
  localparam logic [8:0] VGA_PLANAR_PITCH = 9'h050;
  localparam int CURSOR_LINE_SHIFT = 3;
  localparam logic [10:0] WIDTH_640 = 11'h280;
  localparam logic [10:0] WIDTH_800 = 11'h320;
  localparam logic [10:0] WIDTH_1024 = 11'h400;
  localparam logic [10:0] WIDTH_1280 = 11'h500;

  typedef enum logic [1:0] {RES_640, RES_800, RES_1024, RES_1280} gmo_res_type;
  typedef enum logic [2:0] {
    BUF_FRAME, BUF_COMP, BUF_VGA13, BUF_VGAPLANAR, BUF_CURSOR
  } gmo_buf_type;

  typedef struct packed {
    logic write;
    logic read;
    logic [15:0] addr;
    logic [3:0] byteEn;
    logic [31:0] data;
  } gmo_reg_req_type;

  typedef struct packed {
    logic valid;
    gmo_buf_type sel;
    logic [10:0] x;
    logic [10:0] y;
  } gmo_pix_req_type;

  typedef struct packed {
    logic valid;
    logic inAperture;
    logic [19:0] wordOffset;
    logic [3:0] byteEn;
  } gmo_mem_acc_type;

endpackage : gmo_pkg
